// ---- rtl/ier_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ier_params.svh"
module ier_top
  import ier_pkg::*;
#(
  parameter int SRC_W = `IER_SRC_W,
  parameter int IDX_W = `IER_IDX_W
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [SRC_W-1:0]   src_set,
  input  wire logic               irq_ack,
  output logic                    irq_req,
  output logic      [IDX_W-1:0]   irq_src,
  output logic                    master_enable,
  output logic                    irq
);

  generate
    if (SRC_W != `IER_SRC_W || IDX_W != `IER_IDX_W) begin : g_bad_cfg
      $error("ier_top: source layout is fixed at the documented width"); // RULE1
    end
  endgenerate

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `IER_IDX_EN_HI) || hit(a, `IER_IDX_EN_LO) || hit(a, `IER_IDX_RQ_HI) ||
             hit(a, `IER_IDX_RQ_LO) || hit(a, `IER_IDX_EN_EX) || hit(a, `IER_IDX_RQ_EX) ||
             hit(a, `IER_IDX_CTRL)  || hit(a, `IER_IDX_STAT)  || hit(a, `IER_IDX_MASK);
  endfunction : mapped

  // APB slave state.
  ier_apb_state_t         state_q;
  ier_apb_state_t         state_d;
  logic [31:0]            prdata_q;
  logic [31:0]            prdata_d;
  logic                   pslverr_q;
  logic                   pslverr_d;

  // Control state.
  logic [7:0]             en_hi_q;
  logic [7:0]             en_hi_d;
  logic [7:0]             en_lo_q;
  logic [7:0]             en_lo_d;
  logic [`IER_EX_W-1:0]   en_ex_q;
  logic [`IER_EX_W-1:0]   en_ex_d;
  logic                   master_q;
  logic                   master_d;
  logic [`IER_EV_W-1:0]   stat_q;
  logic [`IER_EV_W-1:0]   stat_d;
  logic [`IER_EV_W-1:0]   mask_q;
  logic [`IER_EV_W-1:0]   mask_d;
  logic                   irq_q;
  logic                   irq_d;
  logic                   req_q;
  logic                   req_d;
  logic [IDX_W-1:0]       src_q;
  logic [IDX_W-1:0]       src_d;

  // Request flags and their combinational neighbours.
  ier_src_t               flags_q;
  ier_src_t               enables;
  ier_src_t               pend;
  ier_src_t               wr_en_vec;
  ier_src_t               wr_val_vec;
  ier_src_t               ack_clr_vec;
  logic                   wr_fire;
  logic                   take;
  logic                   sel_found;
  logic [IDX_W-1:0]       sel_idx;
  logic [`IER_EV_W-1:0]   events;

  assign wr_fire = psel && penable && (state_q == IER_APB_ACCESS) && pwrite && !pslverr_q;
  assign take    = irq_ack && req_q;

  always_comb begin
    enables = '0;
    enables[`IER_HI_LSB +: 8]        = en_hi_q;
    enables[`IER_LO_LSB +: 8]        = en_lo_q & `IER_LO_USED; // RULE6
    enables[`IER_EX_LSB +: `IER_EX_W] = en_ex_q;
  end

  assign pend = flags_q & enables; // RULE2

  // Write-enable and value per request flag, taken from the byte or, for the extension group, the 12 bits that hold it.
  always_comb begin
    wr_en_vec  = '0;
    wr_val_vec = '0;
    if (wr_fire && hit(paddr, `IER_IDX_RQ_HI)) begin
      wr_en_vec[`IER_HI_LSB +: 8]  = 8'hff; // RULE7
      wr_val_vec[`IER_HI_LSB +: 8] = pwdata[7:0]; // RULE8
    end
    if (wr_fire && hit(paddr, `IER_IDX_RQ_LO)) begin
      wr_en_vec[`IER_LO_LSB +: 8]  = `IER_LO_USED;
      wr_val_vec[`IER_LO_LSB +: 8] = pwdata[7:0] & `IER_LO_USED;
    end
    if (wr_fire && hit(paddr, `IER_IDX_RQ_EX)) begin
      wr_en_vec[`IER_EX_LSB +: `IER_EX_W]  = {`IER_EX_W{1'b1}};
      wr_val_vec[`IER_EX_LSB +: `IER_EX_W] = pwdata[`IER_EX_W-1:0];
    end
  end

  always_comb begin
    ack_clr_vec = '0;
    if (take) begin
      ack_clr_vec[src_q] = 1'b1; // RULE10
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SRC_W; gi++) begin : g_flag
      if (gi == `IER_UNUSED_BIT) begin : g_none
        assign flags_q[gi] = 1'b0; // RULE6
      end else begin : g_bit
        ier_flag u_flag (
          .pclk    (pclk),
          .presetn (presetn),
          .set     (src_set[gi]),
          .wr_en   (wr_en_vec[gi]),
          .wr_val  (wr_val_vec[gi]),
          .clr     (ack_clr_vec[gi]),
          .q       (flags_q[gi])
        ); // RULE9
      end
    end
  endgenerate

  ier_prio #(
    .W  (SRC_W),
    .IW (IDX_W)
  ) u_prio (
    .req   (pend),
    .found (sel_found),
    .idx   (sel_idx)
  ); // RULE12

  // APB: registered answer, so every transfer takes exactly one access cycle.
  always_comb begin
    state_d   = state_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    case (state_q)
      IER_APB_IDLE: begin
        if (psel && !penable) begin
          state_d   = IER_APB_ACCESS;
          pslverr_d = !mapped(paddr);
          prdata_d  = 32'h0000_0000;
          if (!pwrite) begin
            if (hit(paddr, `IER_IDX_EN_HI)) begin
              prdata_d[7:0] = en_hi_q; // RULE5
            end
            if (hit(paddr, `IER_IDX_EN_LO)) begin
              prdata_d[7:0] = en_lo_q & `IER_LO_USED; // RULE6
            end
            if (hit(paddr, `IER_IDX_RQ_HI)) begin
              prdata_d[7:0] = flags_q[`IER_HI_LSB +: 8]; // RULE7
            end
            if (hit(paddr, `IER_IDX_RQ_LO)) begin
              prdata_d[7:0] = flags_q[`IER_LO_LSB +: 8];
            end
            if (hit(paddr, `IER_IDX_EN_EX)) begin
              prdata_d[`IER_EX_W-1:0] = en_ex_q;
            end
            if (hit(paddr, `IER_IDX_RQ_EX)) begin
              prdata_d[`IER_EX_W-1:0] = flags_q[`IER_EX_LSB +: `IER_EX_W];
            end
            if (hit(paddr, `IER_IDX_CTRL)) begin
              prdata_d[`IER_CTRL_MASTER] = master_q;
            end
            if (hit(paddr, `IER_IDX_STAT)) begin
              prdata_d[`IER_EV_W-1:0] = stat_q;
            end
            if (hit(paddr, `IER_IDX_MASK)) begin
              prdata_d[`IER_EV_W-1:0] = mask_q;
            end
          end
        end
      end
      IER_APB_ACCESS: begin
        state_d   = IER_APB_IDLE;
        pslverr_d = 1'b0;
      end
      default: begin
        state_d   = IER_APB_IDLE;
        pslverr_d = 1'b0;
      end
    endcase
  end

  // Register writes, acceptance and interrupt status.
  always_comb begin
    en_hi_d  = en_hi_q;
    en_lo_d  = en_lo_q;
    en_ex_d  = en_ex_q;
    master_d = master_q;
    mask_d   = mask_q;
    events   = '0;
    if (wr_fire && hit(paddr, `IER_IDX_EN_HI)) begin
      en_hi_d = pwdata[7:0]; // RULE4
    end
    if (wr_fire && hit(paddr, `IER_IDX_EN_LO)) begin
      en_lo_d = pwdata[7:0] & `IER_LO_USED; // RULE6
    end
    if (wr_fire && hit(paddr, `IER_IDX_EN_EX)) begin
      en_ex_d = pwdata[`IER_EX_W-1:0];
    end
    if (wr_fire && hit(paddr, `IER_IDX_CTRL)) begin
      master_d = pwdata[`IER_CTRL_MASTER];
    end
    if (wr_fire && hit(paddr, `IER_IDX_MASK)) begin
      mask_d = pwdata[`IER_EV_W-1:0];
    end
    // Acceptance beats a same-cycle software set so a handler never starts unmasked.
    if (take) begin
      master_d = 1'b0; // RULE11
    end
    events[`IER_EV_ACCEPT] = take;
    events[`IER_EV_RAISE]  = |(src_set & ~flags_q & ~(ier_src_t'(1) << `IER_UNUSED_BIT));
    stat_d = stat_q;
    if (wr_fire && hit(paddr, `IER_IDX_STAT)) begin
      stat_d = stat_q & ~pwdata[`IER_EV_W-1:0];
    end
    stat_d = stat_d | events;
    irq_d  = |(stat_d & mask_d);
    // The request drops in the cycle after acceptance, before the core can ack twice.
    req_d  = sel_found && master_q && !take; // RULE3
    src_d  = sel_idx;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= IER_APB_IDLE;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      en_hi_q   <= `IER_RST_BYTE;
      en_lo_q   <= `IER_RST_BYTE;
      en_ex_q   <= `IER_RST_EXT;
      master_q  <= 1'b0;
      stat_q    <= `IER_RST_EV;
      mask_q    <= `IER_RST_EV;
      irq_q     <= 1'b0;
      req_q     <= 1'b0;
      src_q     <= '0;
    end else begin
      state_q   <= state_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      en_hi_q   <= en_hi_d;
      en_lo_q   <= en_lo_d;
      en_ex_q   <= en_ex_d;
      master_q  <= master_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      irq_q     <= irq_d;
      req_q     <= req_d;
      src_q     <= src_d;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = (state_q == IER_APB_ACCESS);
  assign pslverr       = pslverr_q;
  assign irq_req       = req_q;
  assign irq_src       = src_q;
  assign master_enable = master_q;
  assign irq           = irq_q;

  ier_src_t below_mask;
  assign below_mask = (28'h000_0001 << src_q) - 28'h000_0001;

  a_master_gates: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    req_q |-> $past(master_q))
    else $error("request offered while master enable was clear");

  a_enable_gates: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    req_q |-> $past(flags_q[sel_idx]) && $past(enables[sel_idx]) && (src_q == $past(sel_idx)))
    else $error("request offered for a disabled or idle source");

  a_prio_single: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    req_q |-> (($past(pend) & below_mask) == '0))
    else $error("a lower index source was pending but not chosen");

  a_ack_clears_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    take && !src_set[src_q] |=> !flags_q[$past(src_q)])
    else $error("accepted source flag still set");

  a_ack_master_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    take |=> !master_q && !req_q)
    else $error("master enable or request survived acceptance");

  a_flag_latched: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    !take && !(wr_fire && pwrite) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("request flag dropped without acceptance or write");

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    |src_set |=> ((flags_q & $past(src_set) & 28'hfff_fdff) == ($past(src_set) & 28'hfff_fdff)))
    else $error("source event lost against a clear");

  a_enable_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    wr_fire && hit(paddr, `IER_IDX_EN_HI) |=> en_hi_q == $past(pwdata[7:0]))
    else $error("high enable write not stored");

  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    !flags_q[`IER_UNUSED_BIT] && !enables[`IER_UNUSED_BIT])
    else $error("unused low bit became set");

  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    psel && !penable && !pready |=> pready ##1 !pready)
    else $error("APB access did not complete in one cycle");

  a_request_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    wr_fire && hit(paddr, `IER_IDX_RQ_HI) && !take |=>
      flags_q[7:0] == ($past(pwdata[7:0]) | $past(src_set[7:0])))
    else $error("request flag write not applied");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq_q == |(stat_q & mask_q))
    else $error("interrupt output differs from masked status");

  c_ext_accept: cover property (@(posedge pclk) disable iff (!presetn)
    take && (src_q > 5'd15));

  c_accept: cover property (@(posedge pclk) disable iff (!presetn)
    req_q ##1 take ##1 !master_q);
  c_two_pending: cover property (@(posedge pclk) disable iff (!presetn)
    req_q && ($countones(pend) > 1));
  c_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
    |(src_set & wr_en_vec & ~wr_val_vec));
  c_irq_out: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_q));

endmodule : ier_top
`default_nettype wire

// ---- rtl/ier_params.svh ----
// Summary of operation
// RULE1 - The block serves 27 interrupt sources, each with its own enable and request flag.
// RULE2 - A pending request is offered only while the enable flag of its source is one.
// RULE3 - A clear master enable bit blocks every maskable interrupt regardless of enables; here it gates irq_req only, not the irq status output.
// RULE4 - An enable flag written as one permits its source, written as zero blocks it.
// RULE5 - High enable bits 7 to 0 are timer0 to timer3 match and overflow, all read/write.
// RULE6 - Low enables 7..2: I2C, serial, watch, UART rx/tx, watchdog; 0 basic timer; 1 unused.
// RULE7 - High request flags are read/write in the same order, timer0 match at bit 7.
// RULE8 - A request flag reads one while pending, and software clears it by writing zero.
// RULE9 - A raised request stays latched until accepted, reset or cleared by software.
// RULE10 - Accepting an interrupt clears the request flag of the accepted source.
// RULE11 - Accepting a maskable interrupt clears the master enable bit until software sets it.
// RULE12 - A fixed priority circuit presents exactly one of several enabled pending requests.
`ifndef IER_PARAMS_SVH
`define IER_PARAMS_SVH

// Register word indices; the byte address is four times the index.
`define IER_IDX_EN_HI   10'h0ea
`define IER_IDX_EN_LO   10'h0eb
`define IER_IDX_RQ_HI   10'h0ec
`define IER_IDX_RQ_LO   10'h0ed
`define IER_IDX_EN_EX   10'h0f0
`define IER_IDX_RQ_EX   10'h0f1
`define IER_IDX_CTRL    10'h0f2
`define IER_IDX_STAT    10'h0f3
`define IER_IDX_MASK    10'h0f4

`define IER_RST_BYTE    8'h00
`define IER_RST_EXT     12'h000
`define IER_RST_EV      2'h0

// Flat source vector: [7:0] high group, [15:8] low group, [27:16] extension group.
`define IER_SRC_W       28
`define IER_IDX_W       5
`define IER_HI_LSB      0
`define IER_LO_LSB      8
`define IER_EX_LSB      16
`define IER_EX_W        12
`define IER_UNUSED_BIT  9
`define IER_LO_USED     8'hfd

`define IER_CTRL_MASTER 0
`define IER_EV_ACCEPT   0
`define IER_EV_RAISE    1
`define IER_EV_W        2

`endif

// ---- rtl/ier_pkg.sv ----
package ier_pkg;

  typedef enum logic [1:0] {
    IER_APB_IDLE   = 2'b01,
    IER_APB_ACCESS = 2'b10
  } ier_apb_state_t;

  typedef logic [27:0] ier_src_t;

endpackage : ier_pkg

// ---- rtl/ier_flag.sv ----
`timescale 1ns/1ps
`default_nettype none
module ier_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic clr,
  output logic      q
);

  logic flag_d;

  // A source event in the same cycle as a clear still leaves the flag set.
  always_comb begin
    flag_d = q;
    if (wr_en) begin
      flag_d = wr_val;
    end
    if (clr) begin
      flag_d = 1'b0;
    end
    if (set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else begin
      q <= flag_d;
    end
  end

endmodule : ier_flag
`default_nettype wire

// ---- rtl/ier_prio.sv ----
`timescale 1ns/1ps
`default_nettype none
module ier_prio #(
  parameter int W  = 28,
  parameter int IW = 5
) (
  input  wire logic [W-1:0]  req,
  output logic               found,
  output logic [IW-1:0]      idx
);

  generate
    if ((1 << IW) < W) begin : g_bad
      $error("ier_prio: index width too small for request width");
    end
  endgenerate

  // Lowest index wins; scanning downward lets the last hit stand.
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule : ier_prio
`default_nettype wire

// ---- verification/ier_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ier_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_src,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack,
  output logic [4:0]      last_src,
  output logic [7:0]      ack_count
);
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic       ack_q;
  logic       ack_d;
  logic [4:0] src_q;
  logic [4:0] src_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // The acknowledge is a single pulse, so the dropping request is never taken twice.
  always_comb begin
    wait_d = 4'h0;
    ack_d  = 1'h0;
    src_d  = src_q;
    cnt_d  = cnt_q;
    if (!ack_q && irq_req) begin
      if (wait_q == ack_delay) begin
        ack_d = 1'h1;
        src_d = irq_src;
        cnt_d = cnt_q + 8'h1;
      end else begin
        wait_d = wait_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      ack_q  <= 1'h0;
      src_q  <= 5'h0;
      cnt_q  <= 8'h0;
    end else begin
      wait_q <= wait_d;
      ack_q  <= ack_d;
      src_q  <= src_d;
      cnt_q  <= cnt_d;
    end
  end

  assign irq_ack   = ack_q;
  assign last_src  = src_q;
  assign ack_count = cnt_q;
endmodule : ier_core_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ier_params.svh"
module tb;
  import ier_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ier_src_t    src_set = 28'h0;
  logic        irq_ack;
  logic        irq_req;
  logic [4:0]  irq_src;
  logic        master_enable;
  logic        irq;
  logic [3:0]  ack_delay = 4'h0;
  logic [4:0]  last_src;
  logic [7:0]  ack_count;
  logic [31:0] rd;
  logic        err;
  int          err_count = 0;
  int          n_tests = 0;

  always #5 pclk = ~pclk;

  ier_top u_ier_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_set(src_set), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_src(irq_src), .master_enable(master_enable), .irq(irq));

  ier_core_model u_ier_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_src(irq_src), .ack_delay(ack_delay), .irq_ack(irq_ack), .last_src(last_src),
    .ack_count(ack_count));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic timed_out(input string name);
    err_count++;
    $display("CHECK FAILED %s expected answer seen timeout", name);
    end_sim();
  endtask : timed_out

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request stays unchanged until the edge that samples pready high.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) timed_out("pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    apb(1'h1, idx, wd);
  endtask : wr

  task automatic rd_chk(input string name, input logic [9:0] idx, input logic [31:0] exp,
                        input logic exp_err);
    apb(1'h0, idx, 32'h0);
    chk(name, exp, rd);
    chk({name, " pslverr"}, {31'h0, exp_err}, {31'h0, err});
  endtask : rd_chk

  task automatic pulse(input ier_src_t v);
    @(posedge pclk);
    src_set <= v;
    @(posedge pclk);
    src_set <= 28'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Waits for the core model to accept one request, then checks what was presented.
  task automatic take(input logic [4:0] exp_src);
    int n;
    logic [7:0] c0;
    c0 = ack_count;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ack_count === c0 && n < 32);
    if (ack_count === c0) timed_out("accept");
    chk("accepted source", {27'h0, exp_src}, {27'h0, last_src});
    repeat (2) @(posedge pclk);
    chk("master after accept", 32'h0, {31'h0, master_enable});
    chk("req after accept", 32'h0, {31'h0, irq_req});
  endtask : take

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk("en_hi reset", `IER_IDX_EN_HI, 32'h0, 1'h0);
    rd_chk("en_lo reset", `IER_IDX_EN_LO, 32'h0, 1'h0);
    rd_chk("rq_hi reset", `IER_IDX_RQ_HI, 32'h0, 1'h0);
    wr(`IER_IDX_EN_HI, 32'h5a);
    rd_chk("en_hi 5a", `IER_IDX_EN_HI, 32'h5a, 1'h0);
    wr(`IER_IDX_EN_HI, 32'ha5);
    rd_chk("en_hi a5", `IER_IDX_EN_HI, 32'ha5, 1'h0);
    wr(`IER_IDX_EN_LO, 32'hffffffff);
    rd_chk("en_lo unused bit", `IER_IDX_EN_LO, 32'hfd, 1'h0);
    wr(`IER_IDX_RQ_HI, 32'h81);
    rd_chk("rq_hi write one", `IER_IDX_RQ_HI, 32'h81, 1'h0);
    wr(`IER_IDX_RQ_HI, 32'h0);
    rd_chk("rq_hi write zero", `IER_IDX_RQ_HI, 32'h0, 1'h0);
    wr(10'h0e0, 32'hff);
    rd_chk("unmapped", 10'h0e0, 32'h0, 1'h1);
    wr(`IER_IDX_CTRL, 32'h1);
    pulse(28'h2);
    chk("req disabled source", 32'h0, {31'h0, irq_req});
    rd_chk("latched flag", `IER_IDX_RQ_HI, 32'h02, 1'h0);
    wr(`IER_IDX_EN_HI, 32'ha7);
    take(5'd1);
    rd_chk("flag cleared by accept", `IER_IDX_RQ_HI, 32'h0, 1'h0);
    pulse(28'h81);
    chk("req master off", 32'h0, {31'h0, irq_req});
    ack_delay <= 4'h3;
    wr(`IER_IDX_CTRL, 32'h1);
    take(5'd0);
    rd_chk("one flag left", `IER_IDX_RQ_HI, 32'h80, 1'h0);
    wr(`IER_IDX_CTRL, 32'h1);
    take(5'd7);
    ack_delay <= 4'h0;
    wr(`IER_IDX_EN_EX, 32'h800);
    pulse(28'h8000100);
    rd_chk("rq_lo pending", `IER_IDX_RQ_LO, 32'h01, 1'h0);
    rd_chk("rq_ex pending", `IER_IDX_RQ_EX, 32'h800, 1'h0);
    rd_chk("en_ex readback", `IER_IDX_EN_EX, 32'h800, 1'h0);
    wr(`IER_IDX_CTRL, 32'h1);
    take(5'd8);
    wr(`IER_IDX_CTRL, 32'h1);
    take(5'd27);
    wr(`IER_IDX_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'h0, `IER_IDX_STAT, 32'h0);
    chk("accept event sticky", 32'h1, rd & 32'h1);
    chk("raise event sticky", 32'h2, rd & 32'h2);
    wr(`IER_IDX_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`IER_IDX_STAT, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'h0, `IER_IDX_STAT, 32'h0);
    chk("status cleared", 32'h0, rd & 32'h3);
    wr(`IER_IDX_RQ_LO, 32'hff);
    rd_chk("rq_lo unused bit", `IER_IDX_RQ_LO, 32'hfd, 1'h0);
    wr(`IER_IDX_RQ_LO, 32'h0);
    rd_chk("rq_lo write zero", `IER_IDX_RQ_LO, 32'h0, 1'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
